// [lsfs_pkg.sv]
// package: constants and types of the led soft-start and fault supervisor
package lsfs_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int HOLD_TIME_NS = 50000;
    localparam int HOLD_CYCLES = HOLD_TIME_NS / CLK_PERIOD_NS;
    localparam int POR_DELAY_CYCLES = 16;
    localparam int STARTUP_BITS = 15;
    localparam int FAULT_FULL_COUNT = 256;
    localparam int FCNT_BITS = 9;
    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h0c;
    localparam logic [4:0] ADDR_COUNTERS = 5'h10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CTRL_DRIVE_ALLOW_BIT = 0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam int IRQ_STARTUP_FAIL_BIT = 0;
    localparam int IRQ_COUNT_FAULT_BIT = 1;
    localparam int IRQ_SHORT_BIT = 2;
    localparam int IRQ_HANDOVER_BIT = 3;
    localparam int IRQ_BITS = 4;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LSFS_ST_POR = 2'b00,
        LSFS_ST_SOFTSTART = 2'b01,
        LSFS_ST_RUN = 2'b10
    } lsfs_state_t;

    // comparator flags and switching clock, as they arrive on the pins
    typedef struct packed {
        logic sw_clk;
        logic node_above_ref;
        logic cs_above_led;
        logic cs_above_oc;
        logic cs_above_short;
        logic vs_above_ov;
        logic uv_below;
    } lsfs_pins_t;

    localparam int PIN_BITS = $bits(lsfs_pins_t);
endpackage : lsfs_pkg

// [lsfs_supervisor.sv]
// module: led soft-start and fault supervisor with avalon-mm registers
`timescale 1ns/1ns
`default_nettype none
module lsfs_supervisor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire lsfs_pkg::lsfs_pins_t pins_in,
    output logic softstart_charge_en,
    output logic node_to_dimming,
    output logic drive_out_a,
    output logic drive_out_b,
    output logic aux_drive_out,
    output logic comp_clamp_en,
    output logic fault_out_n,
    output logic irq
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [lsfs_pkg::PIN_BITS-1:0] sync1, sync2, sync3, filt;
    lsfs_pkg::lsfs_pins_t pin;
    assign pin = lsfs_pkg::lsfs_pins_t'(filt);

    genvar gi;
    generate
        for (gi = 0; gi < lsfs_pkg::PIN_BITS; gi++) begin : g_sync
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    filt[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pins_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        filt[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate

    // one tick per switching period, on the qualified rising edge
    logic tick;
    assign tick = (sync2[lsfs_pkg::PIN_BITS-1] == sync3[lsfs_pkg::PIN_BITS-1])
                  && sync3[lsfs_pkg::PIN_BITS-1] && !pin.sw_clk;

    // ------------------------------------------------------------
    // start-up sequencing
    // ------------------------------------------------------------
    lsfs_pkg::lsfs_state_t state;
    logic [4:0] por_cnt;
    logic [lsfs_pkg::STARTUP_BITS-1:0] startup_cnt;
    logic startup_done;
    logic cs_seen;
    logic fault_latch;
    logic [31:0] ctrl;
    logic startup_fail_ev, handover_ev;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= lsfs_pkg::LSFS_ST_POR;
            por_cnt <= 5'h00;
        end else begin
            case (state)
                lsfs_pkg::LSFS_ST_POR: begin
                    if (por_cnt == 5'(lsfs_pkg::POR_DELAY_CYCLES - 1)) begin
                        state <= lsfs_pkg::LSFS_ST_SOFTSTART;
                    end else begin
                        por_cnt <= por_cnt + 5'h01;
                    end
                end
                lsfs_pkg::LSFS_ST_SOFTSTART: begin
                    if (pin.node_above_ref) begin
                        state <= lsfs_pkg::LSFS_ST_RUN;
                    end
                end
                lsfs_pkg::LSFS_ST_RUN: begin
                    state <= lsfs_pkg::LSFS_ST_RUN;
                end
                default: begin
                    state <= lsfs_pkg::LSFS_ST_POR;
                end
            endcase
        end
    end

    assign handover_ev = (state == lsfs_pkg::LSFS_ST_SOFTSTART) && pin.node_above_ref;

    // start-up timeout counts switching ticks from the end of the reset delay
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            startup_cnt <= '0;
            startup_done <= 1'b0;
            cs_seen <= 1'b0;
        end else begin
            if (state != lsfs_pkg::LSFS_ST_POR && pin.cs_above_led) begin
                cs_seen <= 1'b1;
            end
            if (state != lsfs_pkg::LSFS_ST_POR && !startup_done && tick) begin
                startup_cnt <= startup_cnt + 1'b1;
                if (&startup_cnt) begin
                    startup_done <= 1'b1;
                end
            end
        end
    end

    assign startup_fail_ev = tick && (&startup_cnt) && !startup_done && !cs_seen
                             && state != lsfs_pkg::LSFS_ST_POR;

    // ------------------------------------------------------------
    // fault counter and periodic clear
    // ------------------------------------------------------------
    logic [lsfs_pkg::STARTUP_BITS-1:0] interval_cnt;
    logic [lsfs_pkg::FCNT_BITS-1:0] fault_cnt;
    logic open_cond, count_cond, cs_led_d, hold_clear, count_fault_ev, short_ev;
    logic [2:0] hold_cond, hold_cond_d, hold_clr;
    logic [10:0] hold_cnt [3];

    assign open_cond = startup_done && drive_out_a && !pin.cs_above_led;
    assign hold_cond = {pin.uv_below, pin.vs_above_ov, pin.cs_above_oc};
    assign count_cond = open_cond || (|hold_cond);
    assign hold_clear = |hold_clr;
    assign short_ev = pin.cs_above_short && state != lsfs_pkg::LSFS_ST_POR;

    // one-shot holds for overcurrent, overvoltage and undervoltage
    generate
        for (gi = 0; gi < 3; gi++) begin : g_hold
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    hold_cnt[gi] <= '0;
                    hold_cond_d[gi] <= 1'b0;
                end else begin
                    hold_cond_d[gi] <= hold_cond[gi];
                    if (hold_cond[gi] && !hold_cond_d[gi] && hold_cnt[gi] == '0) begin
                        hold_cnt[gi] <= 11'(lsfs_pkg::HOLD_CYCLES);
                    end else if (hold_cnt[gi] != '0) begin
                        hold_cnt[gi] <= hold_cnt[gi] - 11'h001;
                    end
                end
            end
            assign hold_clr[gi] = (hold_cnt[gi] == 11'h001) && !hold_cond[gi];
        end
    endgenerate

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            interval_cnt <= '0;
            fault_cnt <= '0;
            cs_led_d <= 1'b0;
        end else begin
            cs_led_d <= pin.cs_above_led;
            if (tick) begin
                interval_cnt <= interval_cnt + 1'b1;
            end
            if (tick && (&interval_cnt)) begin
                fault_cnt <= '0;
            end else if (pin.cs_above_led && !cs_led_d && !pin.cs_above_oc && startup_done) begin
                fault_cnt <= '0;
            end else if (hold_clear) begin
                fault_cnt <= '0;
            end else if (tick && count_cond && fault_cnt != 9'(lsfs_pkg::FAULT_FULL_COUNT)) begin
                fault_cnt <= fault_cnt + 9'h001;
            end
        end
    end

    assign count_fault_ev = fault_cnt == 9'(lsfs_pkg::FAULT_FULL_COUNT);

    // ------------------------------------------------------------
    // fault latch and pin outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_latch <= 1'b0;
            fault_out_n <= 1'b1;
        end else begin
            if (startup_fail_ev || count_fault_ev || short_ev) begin
                fault_latch <= 1'b1;
                fault_out_n <= 1'b0;
            end
        end
    end

    logic next_drive;
    assign next_drive = state == lsfs_pkg::LSFS_ST_RUN && pin.node_above_ref && !fault_latch
                        && !short_ev && !startup_fail_ev && !count_fault_ev
                        && ctrl[lsfs_pkg::CTRL_DRIVE_ALLOW_BIT];

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            softstart_charge_en <= 1'b0;
            node_to_dimming <= 1'b0;
            drive_out_a <= 1'b0;
            drive_out_b <= 1'b0;
            aux_drive_out <= 1'b0;
            comp_clamp_en <= 1'b0;
        end else begin
            softstart_charge_en <= state == lsfs_pkg::LSFS_ST_SOFTSTART && !pin.node_above_ref;
            node_to_dimming <= state == lsfs_pkg::LSFS_ST_RUN || handover_ev;
            drive_out_a <= next_drive;
            drive_out_b <= next_drive;
            aux_drive_out <= next_drive;
            comp_clamp_en <= pin.vs_above_ov && state != lsfs_pkg::LSFS_ST_POR;
        end
    end

    // ------------------------------------------------------------
    // avalon-mm slave and interrupts
    // ------------------------------------------------------------
    logic acked;
    logic [lsfs_pkg::IRQ_BITS-1:0] irq_status, irq_mask, events;
    logic req, wr_take;
    assign req = avs_read || avs_write;
    assign wr_take = avs_write && acked;
    assign events = {handover_ev, short_ev && !fault_latch, count_fault_ev && !fault_latch,
                     startup_fail_ev};

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acked <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            acked <= req && !acked;
            avs_waitrequest <= !(req && !acked);
            if (avs_read && !acked) begin
                case (avs_address)
                    lsfs_pkg::ADDR_CTRL: avs_readdata <= ctrl;
                    lsfs_pkg::ADDR_STATUS: avs_readdata <= {22'h000000, pin.sw_clk, pin.uv_below,
                        pin.vs_above_ov, pin.cs_above_oc, pin.cs_above_led, startup_done,
                        fault_latch, drive_out_a, state};
                    lsfs_pkg::ADDR_IRQ_STATUS: avs_readdata <= {28'h0000000, irq_status};
                    lsfs_pkg::ADDR_IRQ_MASK: avs_readdata <= {28'h0000000, irq_mask};
                    lsfs_pkg::ADDR_COUNTERS: avs_readdata <= {8'h00, startup_cnt, fault_cnt};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= lsfs_pkg::CTRL_RESET;
            irq_mask <= lsfs_pkg::IRQ_MASK_RESET;
        end else if (wr_take) begin
            if (avs_address == lsfs_pkg::ADDR_CTRL) begin
                ctrl <= {31'h00000000, avs_writedata[lsfs_pkg::CTRL_DRIVE_ALLOW_BIT]};
            end
            if (avs_address == lsfs_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= avs_writedata[lsfs_pkg::IRQ_BITS-1:0];
            end
        end
    end

    // an event in the clearing cycle survives: set wins over clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_take && avs_address == lsfs_pkg::ADDR_IRQ_STATUS) begin
                irq_status <= (irq_status & ~avs_writedata[lsfs_pkg::IRQ_BITS-1:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // cycles since each hold was armed, counted apart from the hold timers so that a wrong hold length shows up
    logic [10:0] hold_age [3];

    generate
        for (gi = 0; gi < 3; gi++) begin : g_hold_age
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    hold_age[gi] <= 11'h000;
                end else if (hold_cond[gi] && !hold_cond_d[gi] && hold_cnt[gi] == 11'h000) begin
                    hold_age[gi] <= 11'h001;
                end else if (hold_age[gi] != 11'h000 && hold_age[gi] != 11'h7ff) begin
                    hold_age[gi] <= hold_age[gi] + 11'h001;
                end
            end
        end
    endgenerate

    sequence s_short_seen;
        short_ev;
    endsequence

    sequence s_drive_off_latched;
        !drive_out_a && !fault_out_n;
    endsequence

    a_short_drive_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_short_seen |=> s_drive_off_latched)
        else $error("short did not stop drive");
    a_short_armed_soft: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == lsfs_pkg::LSFS_ST_SOFTSTART && pin.cs_above_short) |=> fault_latch)
        else $error("short not armed during soft start");
    a_fault_stays_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        !fault_out_n |=> !fault_out_n && fault_latch)
        else $error("fault released");
    a_drive_needs_node: assert property (@(posedge core_clk) disable iff (sys_rst)
        drive_out_a |-> $past(pin.node_above_ref) && node_to_dimming && aux_drive_out)
        else $error("drive without node above ref");
    a_charge_before_hand: assert property (@(posedge core_clk) disable iff (sys_rst)
        softstart_charge_en |-> !node_to_dimming)
        else $error("charge with node handed over");
    a_handover_stops: assert property (@(posedge core_clk) disable iff (sys_rst)
        handover_ev |=> !softstart_charge_en && node_to_dimming)
        else $error("handover late");
    a_full_count_fault: assert property (@(posedge core_clk) disable iff (sys_rst)
        fault_cnt == 9'(lsfs_pkg::FAULT_FULL_COUNT) |=> !fault_out_n)
        else $error("full count no fault");
    a_interval_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        (tick && (&interval_cnt)) |=> fault_cnt == '0)
        else $error("periodic clear missed");
    a_open_gated: assert property (@(posedge core_clk) disable iff (sys_rst)
        !startup_done |-> !open_cond)
        else $error("open detect during start-up");
    a_oc_hold_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        (hold_age[0] == 11'(lsfs_pkg::HOLD_CYCLES) && !pin.cs_above_oc) |=> fault_cnt == '0)
        else $error("oc hold clear missed");
    a_ov_hold_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        (hold_age[1] == 11'(lsfs_pkg::HOLD_CYCLES) && !pin.vs_above_ov) |=> fault_cnt == '0)
        else $error("ov hold clear missed");
    a_uv_hold_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        (hold_age[2] == 11'(lsfs_pkg::HOLD_CYCLES) && !pin.uv_below) |=> fault_cnt == '0)
        else $error("uv hold clear missed");
    a_clamp_on_ov: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pin.vs_above_ov && state != lsfs_pkg::LSFS_ST_POR) |=> comp_clamp_en)
        else $error("clamp not on");
    a_por_drive_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == lsfs_pkg::LSFS_ST_POR |-> !drive_out_a && fault_out_n && fault_cnt == '0)
        else $error("drive during reset delay");
    a_startup_fail_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        startup_fail_ev |=> !fault_out_n && fault_latch)
        else $error("start-up failure not reported");
endmodule : lsfs_supervisor
`default_nettype wire

// [lsfs_supervisor_tb_top.sv]
// testbench: self-checking bench for the led soft-start and fault supervisor
`timescale 1ns/1ns
`default_nettype none
module lsfs_supervisor_tb_top;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    lsfs_pkg::lsfs_pins_t pins = '0;
    logic softstart_charge_en, node_to_dimming, drive_out_a, drive_out_b, aux_drive_out;
    logic comp_clamp_en, fault_out_n, irq;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] rd;

    lsfs_supervisor lsfs_supervisor_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pins_in(pins), .softstart_charge_en(softstart_charge_en),
        .node_to_dimming(node_to_dimming), .drive_out_a(drive_out_a), .drive_out_b(drive_out_b),
        .aux_drive_out(aux_drive_out), .comp_clamp_en(comp_clamp_en), .fault_out_n(fault_out_n), .irq(irq)
    );

    always #25 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // common tasks
    // ------------------------------------------------------------
    task give_verdict;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // the whole run is about 140k cycles, dominated by the 32768-tick start-up count
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 170000) begin
            bad_count++;
            give_verdict();
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // the request stands until the rising edge at which waitrequest is sampled low; data is taken there
    task bus(input logic is_rd, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge core_clk);
        avs_read <= is_rd;
        avs_write <= ~is_rd;
        avs_address <= a;
        avs_writedata <= wd;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task wr(input logic [4:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b0, a, wd, dummy);
    endtask : wr

    task rdreg(input logic [4:0] a);
        bus(1'b1, a, 32'h0, rd);
    endtask : rdreg

    task wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : wait_cyc

    // one switching tick: two cycles high, two low, long enough for the input filter
    task tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            pins.sw_clk <= 1'b1;
            repeat (2) @(posedge core_clk);
            pins.sw_clk <= 1'b0;
            @(posedge core_clk);
        end
    endtask : tick

    task do_reset;
        @(posedge core_clk);
        sys_rst <= 1'b1;
        pins <= '0;
        wait_cyc(4);
        check({26'h0, fault_out_n, drive_out_a, drive_out_b, aux_drive_out, softstart_charge_en, avs_waitrequest},
              32'h21);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        wait_cyc(10);
        check({31'h0, softstart_charge_en}, 32'h0);
        wait_cyc(12);
        check({30'h0, softstart_charge_en, node_to_dimming}, 32'h2);
    endtask : do_reset

    task handover;
        @(posedge core_clk);
        pins.node_above_ref <= 1'b1;
        wait_cyc(8);
        check({30'h0, softstart_charge_en, node_to_dimming}, 32'h1);
        check({29'h0, drive_out_a, drive_out_b, aux_drive_out}, 32'h7);
    endtask : handover

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task reg_scenario;
        do_reset();
        rdreg(lsfs_pkg::ADDR_CTRL);
        check(rd, lsfs_pkg::CTRL_RESET);
        wr(5'h14, 32'hffff_ffff);
        rdreg(5'h14);
        check(rd, 32'h0);
        rdreg(lsfs_pkg::ADDR_IRQ_MASK);
        check(rd, {28'h0, lsfs_pkg::IRQ_MASK_RESET});
    endtask : reg_scenario

    task drive_scenario;
        do_reset();
        handover();
        rdreg(lsfs_pkg::ADDR_IRQ_STATUS);
        check({31'h0, rd[lsfs_pkg::IRQ_HANDOVER_BIT]}, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(lsfs_pkg::ADDR_IRQ_MASK, 32'h1 << lsfs_pkg::IRQ_HANDOVER_BIT);
        wait_cyc(3);
        check({31'h0, irq}, 32'h1);
        wr(lsfs_pkg::ADDR_IRQ_STATUS, 32'h1 << lsfs_pkg::IRQ_HANDOVER_BIT);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0);
        @(posedge core_clk);
        pins.node_above_ref <= 1'b0;
        wait_cyc(8);
        check({29'h0, drive_out_a, drive_out_b, aux_drive_out}, 32'h0);
        @(posedge core_clk);
        pins.node_above_ref <= 1'b1;
        wr(lsfs_pkg::ADDR_CTRL, 32'h0);
        wait_cyc(8);
        check({29'h0, drive_out_a, drive_out_b, aux_drive_out}, 32'h0);
        wr(lsfs_pkg::ADDR_CTRL, 32'h1);
        wait_cyc(8);
        check({29'h0, drive_out_a, drive_out_b, aux_drive_out}, 32'h7);
    endtask : drive_scenario

    // short during soft start, then handover with the short still present
    task short_scenario;
        do_reset();
        @(posedge core_clk);
        pins.cs_above_short <= 1'b1;
        wait_cyc(8);
        check({31'h0, fault_out_n}, 32'h0);
        handover_blocked();
        @(posedge core_clk);
        pins.cs_above_short <= 1'b0;
        wait_cyc(40);
        check({31'h0, fault_out_n}, 32'h0);
        rdreg(lsfs_pkg::ADDR_IRQ_STATUS);
        check({31'h0, rd[lsfs_pkg::IRQ_SHORT_BIT]}, 32'h1);
    endtask : short_scenario

    task handover_blocked;
        @(posedge core_clk);
        pins.node_above_ref <= 1'b1;
        wait_cyc(8);
        check({29'h0, drive_out_a, drive_out_b, aux_drive_out}, 32'h0);
    endtask : handover_blocked

    // idx selects the pin bit: 0 undervoltage, 1 overvoltage, 3 overcurrent
    task count_scenario(input int idx);
        do_reset();
        handover();
        @(posedge core_clk);
        pins[idx] <= 1'b1;
        tick(10);
        if (idx == 1) check({31'h0, comp_clamp_en}, 32'h1);
        @(posedge core_clk);
        pins[idx] <= 1'b0;
        rdreg(lsfs_pkg::ADDR_COUNTERS);
        check({31'h0, rd[8:0] != 9'h0}, 32'h1);
        wait_cyc(1100);
        if (idx == 1) check({31'h0, comp_clamp_en}, 32'h0);
        rdreg(lsfs_pkg::ADDR_COUNTERS);
        check({23'h0, rd[8:0]}, 32'h0);
        @(posedge core_clk);
        pins[idx] <= 1'b1;
        tick(200);
        check({31'h0, fault_out_n}, 32'h1);
        tick(100);
        check({31'h0, fault_out_n}, 32'h0);
        rdreg(lsfs_pkg::ADDR_IRQ_STATUS);
        check({31'h0, rd[lsfs_pkg::IRQ_COUNT_FAULT_BIT]}, 32'h1);
    endtask : count_scenario

    task open_led_scenario;
        do_reset();
        handover();
        tick(1000);
        rdreg(lsfs_pkg::ADDR_COUNTERS);
        check({23'h0, rd[8:0]}, 32'h0);
        check({31'h0, fault_out_n}, 32'h1);
        @(posedge core_clk);
        pins.cs_above_led <= 1'b1;
        tick(2);
        pins.cs_above_led <= 1'b0;
        tick(31780);
        rdreg(lsfs_pkg::ADDR_STATUS);
        check({31'h0, rd[4]}, 32'h1);
        check({31'h0, fault_out_n}, 32'h1);
        tick(200);
        pins.cs_above_led <= 1'b1;
        tick(2);
        pins.cs_above_led <= 1'b0;
        tick(200);
        check({31'h0, fault_out_n}, 32'h1);
        tick(100);
        check({31'h0, fault_out_n}, 32'h0);
    endtask : open_led_scenario

    initial begin
        reg_scenario();
        drive_scenario();
        short_scenario();
        count_scenario(0);
        count_scenario(1);
        count_scenario(3);
        open_led_scenario();
        give_verdict();
    end
endmodule : lsfs_supervisor_tb_top
`default_nettype wire
